// File: rtl/crs_pkg.sv
// Package for the sensor readout sequencer: constants, modes and carriers
`default_nettype none
package crs_pkg;
  localparam int COL_W = 12;
  localparam int ROW_W = 12;
  localparam int BIN_W = 6;
  localparam int TIME_W = 32;
  localparam int BITS_W = 5;
  localparam logic [BITS_W-1:0] HW_MAX_BITS = 5'h10;
  localparam int SAMPLE_W = 16;
  localparam logic [BIN_W-1:0] BIN_MAX = 6'h20;
  localparam int CLK_HZ = 50_000_000;
  localparam int PIX_SHIFT_NS = 40;
  localparam int PIX_SHIFT_CYC = (PIX_SHIFT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int LINE_SHIFT_NS = 200;
  localparam int LINE_SHIFT_CYC = (LINE_SHIFT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PH_CNT_W = 8;
  localparam int FIFO_AW = 2;
  localparam logic [TIME_W-1:0] TIME_ONE = 32'h00000001;

  typedef enum logic [1:0] {
    CRS_MODE_FULL = 2'h0,
    CRS_MODE_FT = 2'h1
  } crs_mode_t;

  typedef enum logic [3:0] {
    CRS_IDLE = 4'h0,
    CRS_EXPOSE = 4'h1,
    CRS_COMP = 4'h2,
    CRS_FT_MOVE = 4'h3,
    CRS_LINE = 4'h4,
    CRS_PIX = 4'h5,
    CRS_CONV = 4'h6,
    CRS_WAIT = 4'h7,
    CRS_DONE = 4'h8
  } crs_state_t;

  typedef struct packed {
    crs_mode_t mode;
    logic [COL_W-1:0] n_cols;
    logic [ROW_W-1:0] n_lines;
    logic [COL_W-1:0] roi_x0;
    logic [COL_W-1:0] roi_x1;
    logic [ROW_W-1:0] roi_y0;
    logic [ROW_W-1:0] roi_y1;
    logic [BIN_W-1:0] bin_w;
    logic [BIN_W-1:0] bin_h;
    logic [BITS_W-1:0] bits;
    logic [TIME_W-1:0] t_exp;
    logic [TIME_W-1:0] t_comp;
  } crs_cfg_t;

  typedef struct packed {
    logic line_shift;
    logic pix_shift;
    logic dump;
    logic store_shift;
  } crs_clk_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic [COL_W-1:0] col;
    logic [ROW_W-1:0] line;
  } crs_pix_t;
endpackage : crs_pkg
`default_nettype wire

// File: rtl/crs_phase_timer.sv
// Clock phase pulse stretcher: holds a phase high for a fixed count
`default_nettype none
module crs_phase_timer
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [PH_CNT_W-1:0] len,
  output logic busy,
  output logic done
);
  logic [PH_CNT_W-1:0] cnt;
  logic [PH_CNT_W-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (start && cnt == '0) begin
      next_cnt = len;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == 8'h01);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign busy = (cnt != '0);
endmodule : crs_phase_timer
`default_nettype wire

// File: rtl/crs_sequencer.sv
// Sensor readout sequencer: exposure, line/pixel shifting, ROI, binning, frame transfer
// Contract
// - Readout begins by shifting all pixels one line into serial register together.
// - Serial register pixels shift one by one to output node, each digitized.
// - Next line is not transferred until current line is fully digitized.
// - Frame time is readout plus exposure plus shutter compensation.
// - ROI mode digitizes only region pixels, discarding the rest undigitized.
// - Binning sums a rectangle of pixels before preamp; one conversion each.
// - Bin width and height are freely configurable up to hardware limits.
// - Frame transfer: one half integrates, masked half only stores.
// - After frame-transfer exposure, image moves fast into masked storage half.
// - Storage half is read out while exposed half integrates next frame.
// - Bits per sample depend on hardware limit and software setting.
// - Readout monitor is low during readout, high during exposure and compensation.
`default_nettype none
module crs_sequencer
  import crs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic STOP,
  input wire crs_cfg_t CFG,
  input wire logic CONV_DONE,
  input wire logic [SAMPLE_W-1:0] CONV_DATA,
  output crs_clk_t PHASE,
  output logic CONV_START,
  output logic NODE_RESET,
  output logic SHUTTER_OPEN,
  output logic READOUT_N,
  output logic BUSY,
  output logic PIX_VALID,
  output crs_pix_t PIX
);
  crs_state_t state;
  crs_state_t next_state;
  crs_cfg_t cfg;
  crs_cfg_t next_cfg;
  logic [COL_W-1:0] col;
  logic [COL_W-1:0] next_col;
  logic [ROW_W-1:0] line;
  logic [ROW_W-1:0] next_line;
  logic [BIN_W-1:0] bx;
  logic [BIN_W-1:0] next_bx;
  logic [BIN_W-1:0] by;
  logic [BIN_W-1:0] next_by;
  logic [TIME_W-1:0] tmr;
  logic [TIME_W-1:0] next_tmr;
  logic run;
  logic next_run;
  logic ft_exp_run;
  logic next_ft_exp_run;
  logic [BITS_W-1:0] eff_bits;
  logic [SAMPLE_W-1:0] mask;
  logic ph_start;
  logic [PH_CNT_W-1:0] ph_len;
  logic ph_busy;
  logic ph_done;
  logic in_roi_y;
  logic in_roi_x;
  logic grp_wide_end;
  logic grp_high_end;
  crs_clk_t next_phase;
  logic next_conv;
  logic next_node_rst;
  logic next_shut;
  logic next_rd_n;
  logic next_pv;
  crs_pix_t next_pix;

  crs_phase_timer u_phase (
    .clk(CLK),
    .reset(RESET),
    .start(ph_start),
    .len(ph_len),
    .busy(ph_busy),
    .done(ph_done)
  );

  // Hardware caps software's width request
  assign eff_bits = (cfg.bits > HW_MAX_BITS || cfg.bits == '0) ? HW_MAX_BITS : cfg.bits;

  genvar gi;
  generate
    for (gi = 0; gi < SAMPLE_W; gi++) begin : g_mask
      assign mask[gi] = (BITS_W'(gi) < eff_bits);
    end
  endgenerate

  assign in_roi_y = (line >= cfg.roi_y0) && (line <= cfg.roi_y1);
  assign in_roi_x = (col >= cfg.roi_x0) && (col <= cfg.roi_x1);
  assign grp_wide_end = (bx + 1'b1 >= cfg.bin_w) || (col + 1'b1 >= cfg.n_cols);
  assign grp_high_end = (by + 1'b1 >= cfg.bin_h) || (line + 1'b1 >= cfg.n_lines);

  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_col = col;
    next_line = line;
    next_bx = bx;
    next_by = by;
    next_tmr = tmr;
    next_run = run;
    next_ft_exp_run = ft_exp_run;
    next_phase = '0;
    next_conv = 1'b0;
    next_node_rst = 1'b0;
    next_shut = SHUTTER_OPEN;
    next_rd_n = READOUT_N;
    next_pv = 1'b0;
    next_pix = PIX;
    ph_start = 1'b0;
    ph_len = PH_CNT_W'(PIX_SHIFT_CYC);
    if (STOP) begin
      next_run = 1'b0;
    end
    unique case (state)
      CRS_IDLE: begin
        next_rd_n = 1'b1;
        next_shut = 1'b0;
        if (START) begin
          next_cfg = CFG;
          // Clamp binning to the serial register's limit, one pixel minimum
          if (CFG.bin_w == '0) next_cfg.bin_w = 6'h01;
          if (CFG.bin_h == '0) next_cfg.bin_h = 6'h01;
          if (CFG.bin_w > BIN_MAX) next_cfg.bin_w = BIN_MAX;
          if (CFG.bin_h > BIN_MAX) next_cfg.bin_h = BIN_MAX;
          next_run = 1'b1;
          next_tmr = CFG.t_exp;
          next_shut = 1'b1;
          next_state = CRS_EXPOSE;
        end
      end
      CRS_EXPOSE: begin
        next_rd_n = 1'b1;
        if (tmr > TIME_ONE) begin
          next_tmr = tmr - TIME_ONE;
        end else begin
          next_tmr = cfg.t_comp;
          next_shut = (cfg.mode == CRS_MODE_FT);
          next_state = CRS_COMP;
        end
      end
      CRS_COMP: begin
        next_rd_n = 1'b1;
        if (tmr > TIME_ONE) begin
          next_tmr = tmr - TIME_ONE;
        end else begin
          next_line = '0;
          next_by = '0;
          next_state = (cfg.mode == CRS_MODE_FT) ? CRS_FT_MOVE : CRS_LINE;
        end
      end
      CRS_FT_MOVE: begin
        // Fast parallel move of the exposed half into the masked half
        next_rd_n = 1'b0;
        if (!ph_busy && !ph_done) begin
          ph_start = 1'b1;
          ph_len = PH_CNT_W'(LINE_SHIFT_CYC);
          next_phase.line_shift = 1'b1;
          next_phase.store_shift = 1'b1;
        end else if (ph_busy) begin
          next_phase.line_shift = 1'b1;
          next_phase.store_shift = 1'b1;
        end else if (line + 1'b1 >= cfg.n_lines) begin
          next_line = '0;
          next_tmr = cfg.t_exp;
          next_ft_exp_run = 1'b1;
          next_state = CRS_LINE;
        end else begin
          next_line = line + 1'b1;
        end
      end
      CRS_LINE: begin
        next_rd_n = 1'b0;
        if (!ph_busy && !ph_done) begin
          ph_start = 1'b1;
          ph_len = PH_CNT_W'(LINE_SHIFT_CYC);
          next_phase.line_shift = 1'b1;
        end else if (ph_busy) begin
          next_phase.line_shift = 1'b1;
        end else if (!grp_high_end) begin
          // Vertical binning: stack further lines in the serial register
          next_by = by + 1'b1;
          next_line = line + 1'b1;
        end else begin
          next_col = '0;
          next_bx = '0;
          next_node_rst = 1'b1;
          next_state = CRS_PIX;
        end
      end
      CRS_PIX: begin
        next_rd_n = 1'b0;
        if (!ph_busy && !ph_done) begin
          ph_start = 1'b1;
          next_phase.pix_shift = 1'b1;
          // Out-of-region pixels are dumped without conversion
          next_phase.dump = !(in_roi_x && in_roi_y);
        end else if (ph_busy) begin
          next_phase.pix_shift = 1'b1;
          next_phase.dump = !(in_roi_x && in_roi_y);
        end else if (!grp_wide_end) begin
          next_bx = bx + 1'b1;
          next_col = col + 1'b1;
        end else if (in_roi_x && in_roi_y) begin
          next_conv = 1'b1;
          next_state = CRS_CONV;
        end else begin
          next_state = CRS_WAIT;
        end
      end
      CRS_CONV: begin
        next_rd_n = 1'b0;
        if (CONV_DONE) begin
          next_pv = 1'b1;
          next_pix.data = CONV_DATA & mask;
          next_pix.col = col;
          next_pix.line = line;
          next_state = CRS_WAIT;
        end
      end
      CRS_WAIT: begin
        next_rd_n = 1'b0;
        next_bx = '0;
        next_node_rst = 1'b1;
        if (col + 1'b1 < cfg.n_cols) begin
          next_col = col + 1'b1;
          next_state = CRS_PIX;
        end else if (line + 1'b1 < cfg.n_lines) begin
          // Only now may the next line enter the serial register
          next_line = line + 1'b1;
          next_by = '0;
          next_state = CRS_LINE;
        end else begin
          next_state = CRS_DONE;
        end
      end
      CRS_DONE: begin
        next_rd_n = 1'b1;
        next_ft_exp_run = 1'b0;
        if (!run) begin
          next_shut = 1'b0;
          next_state = CRS_IDLE;
        end else if (cfg.mode == CRS_MODE_FT) begin
          // Exposure continued during readout; only the remainder is waited
          next_state = (tmr == '0) ? CRS_COMP : CRS_EXPOSE;
          if (tmr == '0) next_tmr = cfg.t_comp;
        end else begin
          next_tmr = cfg.t_exp;
          next_shut = 1'b1;
          next_state = CRS_EXPOSE;
        end
      end
      default: begin
        next_state = CRS_IDLE;
      end
    endcase
    // Frame-transfer integration timer runs alongside readout
    if (ft_exp_run && state != CRS_DONE && tmr != '0) begin
      next_tmr = tmr - TIME_ONE;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= CRS_IDLE;
      cfg <= '0;
      col <= '0;
      line <= '0;
      bx <= '0;
      by <= '0;
      tmr <= '0;
      run <= 1'b0;
      ft_exp_run <= 1'b0;
      PHASE <= '0;
      CONV_START <= 1'b0;
      NODE_RESET <= 1'b0;
      SHUTTER_OPEN <= 1'b0;
      READOUT_N <= 1'b1;
      BUSY <= 1'b0;
      PIX_VALID <= 1'b0;
      PIX <= '0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      col <= next_col;
      line <= next_line;
      bx <= next_bx;
      by <= next_by;
      tmr <= next_tmr;
      run <= next_run;
      ft_exp_run <= next_ft_exp_run;
      PHASE <= next_phase;
      CONV_START <= next_conv;
      NODE_RESET <= next_node_rst;
      SHUTTER_OPEN <= next_shut;
      READOUT_N <= next_rd_n;
      BUSY <= (next_state != CRS_IDLE);
      PIX_VALID <= next_pv;
      PIX <= next_pix;
    end
  end
endmodule : crs_sequencer
`default_nettype wire

// File: test/crs_seq_properties.sv
// Port timing checker for the readout sequencer
`default_nettype none
module crs_seq_properties
  import crs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic STOP,
  input wire crs_cfg_t CFG,
  input wire logic CONV_DONE,
  input wire logic [SAMPLE_W-1:0] CONV_DATA,
  input wire crs_clk_t PHASE,
  input wire logic CONV_START,
  input wire logic NODE_RESET,
  input wire logic SHUTTER_OPEN,
  input wire logic READOUT_N,
  input wire logic BUSY,
  input wire logic PIX_VALID,
  input wire crs_pix_t PIX
);
  logic [16:0] mask;
  // Out-of-range widths fall back to the hardware maximum
  assign mask = (CFG.bits == 5'h00 || CFG.bits > HW_MAX_BITS) ? 17'h0ffff : (17'h00001 << CFG.bits) - 17'h00001;
  // High from a conversion request until its sample is handed on; a safety flag instead of an open-ended until
  logic conv_open;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      conv_open <= 1'b0;
    end else if (CONV_START) begin
      conv_open <= 1'b1;
    end else if (PIX_VALID) begin
      conv_open <= 1'b0;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  AST_BUSY_START: assert property (!BUSY && START |=> BUSY && SHUTTER_OPEN) else $error("run did not start");
  AST_LINE_HOLD: assert property ($rose(PHASE.line_shift) |-> PHASE.line_shift[*8]) else $error("short line");
  AST_PIX_HOLD: assert property ($rose(PHASE.pix_shift) |-> PHASE.pix_shift[*2]) else $error("short pix");
  AST_VALID_CAUSE: assert property (PIX_VALID |-> $past(CONV_DONE)) else $error("sample without answer");
  AST_CONV_HOLD: assert property (conv_open |-> !PHASE.line_shift) else $error("early line");
  AST_CONV_BOUND: assert property (CONV_START |-> ##[1:300] PIX_VALID) else $error("sample missing");
  AST_READOUT_LOW: assert property (PHASE.line_shift || PHASE.pix_shift || CONV_START |-> !READOUT_N)
    else $error("monitor high in readout");
  AST_IDLE_HIGH: assert property (!BUSY |-> READOUT_N) else $error("monitor low when idle");
  AST_FULL_DARK: assert property (CFG.mode == CRS_MODE_FULL && PHASE.pix_shift |-> !SHUTTER_OPEN)
    else $error("shutter open in readout");
  AST_FT_OPEN: assert property (CFG.mode == CRS_MODE_FT && PHASE.pix_shift |-> SHUTTER_OPEN)
    else $error("exposed half not integrating");
  AST_BITS: assert property (PIX_VALID |-> PIX.data == ($past(CONV_DATA) & mask[15:0])) else $error("bad width");
  cover property (PIX_VALID);
  cover property ($rose(PHASE.store_shift));
  cover property ($rose(PHASE.dump));
endmodule : crs_seq_properties
bind crs_sequencer crs_seq_properties u_crs_seq_properties (.CLK(CLK), .RESET(RESET), .START(START), .STOP(STOP),
  .CFG(CFG), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .PHASE(PHASE), .CONV_START(CONV_START),
  .NODE_RESET(NODE_RESET), .SHUTTER_OPEN(SHUTTER_OPEN), .READOUT_N(READOUT_N), .BUSY(BUSY),
  .PIX_VALID(PIX_VALID), .PIX(PIX));
`default_nettype wire

// File: test/crs_digitizer_model.sv
// Behavioural digitizer answering conversion requests
`default_nettype none
module crs_digitizer_model
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic slow,
  output logic conv_done,
  output logic [SAMPLE_W-1:0] conv_data
);
  logic pending;
  logic [7:0] wait_cnt;
  logic [SAMPLE_W-1:0] seq;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pending <= 1'b0;
      wait_cnt <= 8'h00;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
      seq <= 16'hf3a5;
    end else begin
      conv_done <= 1'b0;
      // Result is only good with the answer; scramble it otherwise
      conv_data <= ~conv_data;
      if (conv_start) begin
        pending <= 1'b1;
        wait_cnt <= slow ? 8'h14 : 8'h01;
      end else if (pending && wait_cnt == 8'h00) begin
        pending <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= seq;
        seq <= seq + 16'h1111;
      end else if (pending) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
endmodule : crs_digitizer_model
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the readout sequencer
`default_nettype none
module tb
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic stop = 1'b0;
  logic slow = 1'b0;
  crs_cfg_t cfg = '0;
  logic conv_done;
  logic [SAMPLE_W-1:0] conv_data;
  crs_clk_t phase;
  crs_clk_t prev = '0;
  logic conv_start;
  logic busy;
  logic node_reset;
  logic pix_valid;
  crs_pix_t pix;
  crs_pix_t last_pix;
  int bad_count = 0;
  int cmp_count = 0;
  int n_conv, n_line, n_pix, n_store, n_dump, n_open, n_rst;
  logic [15:0] or_data;
  always #10 clk = ~clk;
  crs_sequencer u_crs_sequencer (.CLK(clk), .RESET(reset), .START(start), .STOP(stop), .CFG(cfg),
    .CONV_DONE(conv_done), .CONV_DATA(conv_data), .PHASE(phase), .CONV_START(conv_start), .NODE_RESET(node_reset),
    .SHUTTER_OPEN(), .READOUT_N(), .BUSY(busy), .PIX_VALID(pix_valid), .PIX(pix));
  crs_digitizer_model u_crs_digitizer_model (.clk(clk), .reset(reset), .conv_start(conv_start), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));
  always @(posedge clk) begin
    if (pix_valid === 1'b1) begin
      n_conv++;
      or_data |= pix.data;
      last_pix = pix;
    end
    n_line += int'(phase.line_shift && !prev.line_shift);
    n_pix += int'(phase.pix_shift && !prev.pix_shift);
    n_store += int'(phase.store_shift && !prev.store_shift);
    n_dump += int'(phase.dump && !prev.dump);
    n_open += int'(busy && u_crs_sequencer.SHUTTER_OPEN);
    n_rst += int'(node_reset === 1'b1);
    prev = phase;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic crs_cfg_t mk(input crs_mode_t m, input int bw, bh, x1, y0, y1, b);
    crs_cfg_t c;
    c = '0;
    c.mode = m;
    c.n_cols = 12'h004;
    c.n_lines = 12'h003;
    c.roi_x0 = (x1 == 2) ? 12'h001 : 12'h000;
    c.roi_x1 = COL_W'(x1);
    c.roi_y0 = ROW_W'(y0);
    c.roi_y1 = ROW_W'(y1);
    c.bin_w = BIN_W'(bw);
    c.bin_h = BIN_W'(bh);
    c.bits = BITS_W'(b);
    c.t_exp = 32'h00000005;
    c.t_comp = 32'h00000003;
    return c;
  endfunction : mk
  // One frame: stop is requested during exposure so the run ends after it
  task automatic run(input crs_cfg_t c);
    int i;
    @(negedge clk);
    cfg = c;
    start = 1'b1;
    {n_conv, n_line, n_pix, n_store, n_dump, n_open, n_rst} = '0;
    last_pix = '0;
    or_data = 16'h0000;
    @(negedge clk);
    start = 1'b0;
    stop = 1'b1;
    @(negedge clk);
    stop = 1'b0;
    for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    if (i == 20000) begin
      bad_count++;
      stop_test();
    end
  endtask : run
  task automatic test_full();
    run(mk(CRS_MODE_FULL, 1, 1, 3, 0, 2, 12));
    check("conversions", n_conv, 12);
    check("line shifts", n_line, 3);
    check("pixel shifts", n_pix, 12);
    check("exposure cycles", n_open, 5);
    check("node cleared per group", n_rst >= 12, 1);
    check("bits above width", or_data & 16'hf000, 0);
    $display("test full done");
  endtask : test_full
  task automatic test_roi();
    run(mk(CRS_MODE_FULL, 1, 1, 2, 1, 1, 16));
    check("roi conversions", n_conv, 2);
    check("roi line shifts", n_line, 3);
    check("roi discards seen", n_dump != 0, 1);
    check("roi last column", last_pix.col, 2);
    check("roi last line", last_pix.line, 1);
    $display("test roi done");
  endtask : test_roi
  task automatic test_bin();
    run(mk(CRS_MODE_FULL, 2, 3, 3, 0, 2, 16));
    check("bin conversions", n_conv, 2);
    check("bin pixel shifts", n_pix, 4);
    run(mk(CRS_MODE_FULL, 3, 2, 3, 0, 2, 16));
    check("partial bin conversions", n_conv, 4);
    check("partial bin last column", last_pix.col, 3);
    check("partial bin last line", last_pix.line, 2);
    // Zero width and an oversized height are clamped; an oversized width request falls back to the maximum
    run(mk(CRS_MODE_FULL, 0, 40, 3, 0, 2, 20));
    check("clamped bin conversions", n_conv, 4);
    check("clamped bin line shifts", n_line, 3);
    $display("test bin done");
  endtask : test_bin
  task automatic test_ft();
    slow = 1'b1;
    run(mk(CRS_MODE_FT, 1, 1, 3, 0, 2, 0));
    check("store shifts", n_store, 3);
    check("ft conversions", n_conv, 12);
    slow = 1'b0;
    $display("test frame transfer done");
  endtask : test_ft
  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    test_full();
    test_roi();
    test_bin();
    test_ft();
    stop_test();
  end
endmodule : tb
`default_nettype wire
